//--- include/voice_host_map.vh
// Register offsets, field positions and reset values of the voice host pin block.
// Assumes a 32-bit APB slave with byte addresses, one aligned word per register.
//
// Functional notes
// RULE1: Grant low drives memory address and output enable; grant high floats them.
// RULE2: Host write with select high is a subcommand, low is a command.
// RULE3: Write strobe is ignored completely while chip select is high.
// RULE4: Strap high selects the serial host link, low selects the parallel bus.
// RULE5: Parallel mode: pins take data on write low, show status on read low.
// RULE6: Serial mode: pin seven data in, pin six clock in, pin five status out.
// RULE7: In serial mode the host holds data pin four at ground.
// RULE8: Serial mode shows channel status on pins three to zero, channel four highest.
// RULE9: Status select high shows the ready flag, low shows the active-low busy flag.
// RULE10: Reset low initialises state, halts the oscillator and grounds both audio outputs.
// RULE11: Board holds the four factory test inputs low during operation.
// RULE12: Parallel mode: data pins float whenever the read strobe is inactive.
`ifndef VOICE_HOST_MAP_VH
`define VOICE_HOST_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define VH_CTRL_OFS        8'h00
`define VH_RX_OFS          8'h04
`define VH_CHAN_OFS        8'h08
`define VH_MEM_OFS         8'h0c
`define VH_AUDIO_OFS       8'h10
`define VH_PIN_OFS         8'h14
`define VH_IRQ_STAT_OFS    8'h18
`define VH_IRQ_EN_OFS      8'h1c
`define VH_IRQ_CLR_OFS     8'h20

// ****************************************
// Field positions
// ****************************************
`define VH_CTRL_OSC_BIT    0
`define VH_RX_SUB_BIT      8
`define VH_RX_VALID_BIT    9
`define VH_CHAN_BUSY_LSB   4
`define VH_MEM_OE_BIT      24
`define VH_AUDIO_R_LSB     16
`define VH_PIN_SERIAL_BIT  8
`define VH_PIN_GRANT_BIT   9
`define VH_PIN_TEST_LSB    10
`define VH_PIN_SPARE_BIT   14
`define VH_IRQ_CMD_BIT     0
`define VH_IRQ_SUB_BIT     1
`define VH_IRQ_OVR_BIT     2
`define VH_IRQ_READ_BIT    3

// ****************************************
// Reset values
// ****************************************
`define VH_CTRL_RST        1'b0
`define VH_CHAN_RST        4'h0
`define VH_MEM_RST         24'h000000
`define VH_IRQ_RST         4'h0
`define VH_SYNC_RST        27'h0000047

`endif

//--- design/serial_host_shifter.v
// Serial host link shifter: takes command bytes in and shifts status out.
// Assumes clock and data pins are already synchronised to clk.
`timescale 1ns/100ps
module serial_host_shifter (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       frame,
  input  wire       sclk,
  input  wire       sdata,
  input  wire [7:0] status,
  output reg        byte_done,
  output reg  [7:0] rx_byte,
  output reg        sout
);

  reg       sclk_prev_q;
  reg [2:0] cnt_q;
  reg [7:0] rx_sh_q;
  reg [7:0] tx_sh_q;
  wire      sclk_rise;
  wire      sclk_fall;

  assign sclk_rise = sclk & ~sclk_prev_q;
  assign sclk_fall = ~sclk & sclk_prev_q;

  // ****************************************
  // Shift registers
  // ****************************************
  // Bits enter on the clock rise, MSB first; status leaves on the fall so it is
  // stable when the host samples on the next rise.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
      cnt_q       <= 3'h0;
      rx_sh_q     <= 8'h00;
      tx_sh_q     <= 8'h00;
      rx_byte     <= 8'h00;
      byte_done   <= 1'b0;
      sout        <= 1'b0;
    end else begin
      sclk_prev_q <= sclk;
      byte_done   <= 1'b0;
      if (!frame) begin
        cnt_q   <= 3'h0;
        tx_sh_q <= status;
        sout    <= status[7];
      end else begin
        if (sclk_rise) begin // RULE6
          rx_sh_q <= {rx_sh_q[6:0], sdata};
          cnt_q   <= cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            byte_done <= 1'b1;
            rx_byte   <= {rx_sh_q[6:0], sdata};
          end
        end
        if (sclk_fall) begin // RULE6
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
          sout    <= tx_sh_q[6];
        end
      end
    end
  end

endmodule // serial_host_shifter

//--- design/voice_host_pins.v
// Host and voice memory pin logic of the four channel voice playback device.
// Assumes all host and memory pins are asynchronous to pclk; software on APB
// consumes received bytes and supplies channel status and audio samples.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "voice_host_map.vh"
module voice_host_pins #(
  parameter ADDR_W  = 24,
  parameter AUDIO_W = 14,
  parameter CH_N    = 4
) (
  input  wire               pclk,
  input  wire               presetn,
  input  wire [7:0]         paddr,
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [31:0]        pwdata,
  output reg  [31:0]        prdata,
  output wire               pready,
  output reg                pslverr,
  output wire               irq,
  input  wire               host_cs_n,
  input  wire               host_wr_n,
  input  wire               host_rd_n,
  input  wire               cmd_sub_sel,
  input  wire               serial_sel,
  input  wire               status_sel,
  input  wire [7:0]         host_data_in,
  output reg  [7:0]         host_data_out,
  output wire [7:0]         host_data_oe,
  input  wire               voice_mem_bus_grant_n,
  output reg  [ADDR_W-1:0]  voice_mem_addr,
  output wire               voice_mem_addr_oe,
  output reg                voice_mem_oe_n,
  output wire               voice_mem_oe_n_oe,
  input  wire [7:0]         voice_mem_rdata,
  input  wire [3:0]         factory_test_in,
  output reg                osc_run,
  output reg  [AUDIO_W-1:0] left_audio_out,
  output reg  [AUDIO_W-1:0] right_audio_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Strobes and grant start high in reset: no false edge, memory pins float on release.
  wire [26:0] pins_raw;
  reg  [26:0] sync1_q;
  reg  [26:0] sync2_q;

  assign pins_raw = {voice_mem_rdata, host_data_in, factory_test_in,
                     voice_mem_bus_grant_n, status_sel, serial_sel,
                     cmd_sub_sel, host_rd_n, host_wr_n, host_cs_n};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= `VH_SYNC_RST;
      sync2_q <= `VH_SYNC_RST;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire       cs_n_s;
  wire       wr_n_s;
  wire       rd_n_s;
  wire       cmd_s;
  wire       serial_s;
  wire       stsel_s;
  wire       grant_n_s;
  wire [3:0] test_s;
  wire [7:0] din_s;
  wire [7:0] mem_rdata_s;

  assign cs_n_s      = sync2_q[0];
  assign wr_n_s      = sync2_q[1];
  assign rd_n_s      = sync2_q[2];
  assign cmd_s       = sync2_q[3];
  assign serial_s    = sync2_q[4];
  assign stsel_s     = sync2_q[5];
  assign grant_n_s   = sync2_q[6];
  assign test_s      = sync2_q[10:7];
  assign din_s       = sync2_q[18:11];
  assign mem_rdata_s = sync2_q[26:19];

  // ****************************************
  // Software registers
  // ****************************************
  reg              osc_en_q;
  reg [CH_N-1:0]   ready_q;
  reg [CH_N-1:0]   busy_q;
  reg [ADDR_W-1:0] mem_addr_q;
  reg              mem_oe_q;
  reg [AUDIO_W-1:0] audio_l_q;
  reg [AUDIO_W-1:0] audio_r_q;
  reg [3:0]        irq_stat_q;
  reg [3:0]        irq_en_q;
  reg [7:0]        rx_byte_q;
  reg              rx_sub_q;
  reg              rx_valid_q;

  // ****************************************
  // Channel status selection
  // ****************************************
  wire [CH_N-1:0] chan_status;
  wire [7:0]      status_byte;

  assign chan_status = stsel_s ? ready_q : ~busy_q; // RULE9
  assign status_byte = {{(8-CH_N){1'b0}}, chan_status};

  // ****************************************
  // Host write capture
  // ****************************************
  reg        wr_prev_q;
  reg        rd_prev_q;
  wire       par_wr_done;
  wire       ser_byte_done;
  wire [7:0] ser_byte;
  wire       ser_sout;
  wire       ser_frame;
  wire       byte_done;
  wire [7:0] byte_in;
  wire       host_read_start;

  // The byte is taken on the rising write strobe, when parallel data has settled.
  assign par_wr_done = ~serial_s & wr_n_s & ~wr_prev_q & ~cs_n_s; // RULE3 RULE5
  assign ser_frame   = serial_s & ~cs_n_s; // RULE4
  assign byte_done   = serial_s ? ser_byte_done : par_wr_done; // RULE4
  assign byte_in     = serial_s ? ser_byte : din_s;
  assign host_read_start = ~serial_s & ~rd_n_s & rd_prev_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
    end else begin
      wr_prev_q <= wr_n_s;
      rd_prev_q <= rd_n_s;
    end
  end

  serial_host_shifter u_serial (
    .clk       (pclk),
    .rst_n     (presetn),
    .frame     (ser_frame),
    .sclk      (din_s[6]),
    .sdata     (din_s[7]),
    .status    (status_byte),
    .byte_done (ser_byte_done),
    .rx_byte   (ser_byte),
    .sout      (ser_sout)
  );

  // ****************************************
  // Host data pins
  // ****************************************
  // Pins 7, 6 and 4 stay inputs in serial mode; the host grounds pin 4.
  wire [7:0] ser_oe;
  assign ser_oe       = 8'h2f; // RULE6 RULE8 RULE7
  assign host_data_oe = serial_s ? ser_oe : (rd_n_s ? 8'h00 : 8'hff); // RULE5 RULE12

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_data_out <= 8'h00;
    end else if (serial_s) begin
      host_data_out <= {2'b00, ser_sout, 1'b0, status_byte[3:0]}; // RULE8
    end else begin
      host_data_out <= status_byte; // RULE5
    end
  end

  // ****************************************
  // Voice memory pins
  // ****************************************
  assign voice_mem_addr_oe = ~grant_n_s; // RULE1
  assign voice_mem_oe_n_oe = ~grant_n_s; // RULE1

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voice_mem_addr  <= `VH_MEM_RST;
      voice_mem_oe_n  <= 1'b1;
      osc_run         <= 1'b0;
      left_audio_out  <= {AUDIO_W{1'b0}};
      right_audio_out <= {AUDIO_W{1'b0}};
    end else begin
      voice_mem_addr  <= mem_addr_q;
      voice_mem_oe_n  <= ~mem_oe_q;
      osc_run         <= osc_en_q; // RULE10
      left_audio_out  <= audio_l_q;
      right_audio_out <= audio_r_q;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state lets read data come from a flop instead of the decoder.
  reg         ack_q;
  wire        access;
  wire        wr_en;
  wire        rd_en;
  reg  [31:0] rd_mux;
  reg         mapped;

  assign pready = ack_q;
  assign access = psel & penable & ack_q;
  assign wr_en  = access & pwrite;
  assign rd_en  = access & ~pwrite;

  always @* begin
    rd_mux = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      `VH_CTRL_OFS: begin
        rd_mux[`VH_CTRL_OSC_BIT] = osc_en_q;
      end
      `VH_RX_OFS: begin
        rd_mux[7:0]              = rx_byte_q;
        rd_mux[`VH_RX_SUB_BIT]   = rx_sub_q;
        rd_mux[`VH_RX_VALID_BIT] = rx_valid_q;
      end
      `VH_CHAN_OFS: begin
        rd_mux[CH_N-1:0] = ready_q;
        rd_mux[`VH_CHAN_BUSY_LSB +: CH_N] = busy_q;
      end
      `VH_MEM_OFS: begin
        rd_mux[ADDR_W-1:0]      = mem_addr_q;
        rd_mux[`VH_MEM_OE_BIT]  = mem_oe_q;
      end
      `VH_AUDIO_OFS: begin
        rd_mux[AUDIO_W-1:0]                  = audio_l_q;
        rd_mux[`VH_AUDIO_R_LSB +: AUDIO_W]   = audio_r_q;
      end
      `VH_PIN_OFS: begin
        rd_mux[7:0]                   = mem_rdata_s;
        rd_mux[`VH_PIN_SERIAL_BIT]    = serial_s;
        rd_mux[`VH_PIN_GRANT_BIT]     = grant_n_s;
        rd_mux[`VH_PIN_TEST_LSB +: 4] = test_s;
        rd_mux[`VH_PIN_SPARE_BIT]     = din_s[4];
      end
      `VH_IRQ_STAT_OFS: begin
        rd_mux[3:0] = irq_stat_q;
      end
      `VH_IRQ_EN_OFS: begin
        rd_mux[3:0] = irq_en_q;
      end
      `VH_IRQ_CLR_OFS: begin
        rd_mux = 32'h00000000;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q   <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      ack_q   <= psel & penable & ~ack_q;
      prdata  <= rd_mux;
      pslverr <= ~mapped;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Every register returns to its documented idle value, so the oscillator
  // and both audio outputs stay quiet until software enables them.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en_q  <= `VH_CTRL_RST; // RULE10
      ready_q   <= `VH_CHAN_RST;
      busy_q    <= `VH_CHAN_RST;
      mem_addr_q <= `VH_MEM_RST;
      mem_oe_q  <= 1'b0;
      audio_l_q <= {AUDIO_W{1'b0}}; // RULE10
      audio_r_q <= {AUDIO_W{1'b0}}; // RULE10
      irq_en_q  <= `VH_IRQ_RST;
    end else if (wr_en) begin
      case (paddr)
        `VH_CTRL_OFS: begin
          osc_en_q <= pwdata[`VH_CTRL_OSC_BIT];
        end
        `VH_CHAN_OFS: begin
          ready_q <= pwdata[CH_N-1:0];
          busy_q  <= pwdata[`VH_CHAN_BUSY_LSB +: CH_N];
        end
        `VH_MEM_OFS: begin
          mem_addr_q <= pwdata[ADDR_W-1:0];
          mem_oe_q   <= pwdata[`VH_MEM_OE_BIT];
        end
        `VH_AUDIO_OFS: begin
          audio_l_q <= pwdata[AUDIO_W-1:0];
          audio_r_q <= pwdata[`VH_AUDIO_R_LSB +: AUDIO_W];
        end
        `VH_IRQ_EN_OFS: begin
          irq_en_q <= pwdata[3:0];
        end
        default: begin
          osc_en_q <= osc_en_q;
        end
      endcase
    end
  end

  // ****************************************
  // Receive holding register and events
  // ****************************************
  // A new byte beats a same-cycle read pop and stays valid; an unread byte is overwritten and flags overrun.
  wire       rx_pop;
  wire       irq_clr;
  wire [3:0] irq_ev;

  assign rx_pop  = rd_en & (paddr == `VH_RX_OFS);
  assign irq_clr = wr_en & (paddr == `VH_IRQ_CLR_OFS);
  assign irq_ev  = {host_read_start,
                    byte_done & rx_valid_q & ~rx_pop,
                    byte_done & cmd_s,
                    byte_done & ~cmd_s}; // RULE2

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_byte_q  <= 8'h00;
      rx_sub_q   <= 1'b0;
      rx_valid_q <= 1'b0;
    end else if (byte_done) begin
      rx_byte_q  <= byte_in;
      rx_sub_q   <= cmd_s; // RULE2
      rx_valid_q <= 1'b1;
    end else if (rx_pop) begin
      rx_valid_q <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= `VH_IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(irq_clr ? pwdata[3:0] : 4'h0)) | irq_ev;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

endmodule // voice_host_pins

//--- tb/voice_host_pins_checker.sv
// Port checker for the voice host pin block, bound to its top module.
// Assumes every pin input passes two sync flops before it acts.
`timescale 1ns/100ps
module voice_host_pins_checker #(
  parameter AUDIO_W = 14
) (
  input wire               pclk,
  input wire               presetn,
  input wire               psel,
  input wire               penable,
  input wire               pready,
  input wire               pslverr,
  input wire               serial_sel,
  input wire               host_rd_n,
  input wire [7:0]         host_data_oe,
  input wire               voice_mem_bus_grant_n,
  input wire               voice_mem_addr_oe,
  input wire               voice_mem_oe_n_oe,
  input wire               osc_run,
  input wire [AUDIO_W-1:0] left_audio_out,
  input wire [AUDIO_W-1:0] right_audio_out
);
  default clocking dck @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // Checks
  // ****
  // Three samples cover both sync flops, so a slow path still fails here.
  chk_grant_drive: assert property ((!voice_mem_bus_grant_n)[*3] |->
    voice_mem_addr_oe && voice_mem_oe_n_oe)
    else $error("memory pins not driven");
  chk_grant_float: assert property (voice_mem_bus_grant_n[*3] |->
    !voice_mem_addr_oe && !voice_mem_oe_n_oe)
    else $error("memory pins not floated");
  chk_grant_reset: assert property ($rose(presetn) |->
    !voice_mem_addr_oe && !voice_mem_oe_n_oe)
    else $error("memory pins driven after reset");
  chk_par_drive: assert property ((!serial_sel && !host_rd_n)[*3] |-> host_data_oe == 8'hff)
    else $error("status not driven on read");
  chk_par_float: assert property ((!serial_sel && host_rd_n)[*3] |-> host_data_oe == 8'h00)
    else $error("data pins not released");
  chk_ser_pins: assert property (serial_sel[*3] |-> host_data_oe == 8'h2f)
    else $error("serial pin directions wrong");
  chk_reset_quiet: assert property ($rose(presetn) |->
    !osc_run && left_audio_out == 0 && right_audio_out == 0)
    else $error("not quiet after reset");
  chk_apb_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("wait state wrong");
  cov_err: cover property (pready && pslverr);
  cov_read: cover property ((!serial_sel && !host_rd_n)[*3]);
  cov_serial: cover property (serial_sel[*3]);
endmodule // voice_host_pins_checker

bind voice_host_pins voice_host_pins_checker #(.AUDIO_W(AUDIO_W)) i_chk (.*);

//--- tb/host_model.sv
// Host processor model driving the parallel bus or the serial link pins.
// Assumes the bench resolves the shared data pins from both enables.
`timescale 1ns/100ps
module host_model (
  input  wire       pclk,
  input  wire [7:0] host_data_out,
  output reg        host_cs_n,
  output reg        host_wr_n,
  output reg        host_rd_n,
  output reg        cmd_sub_sel,
  output wire [7:0] host_pin
);
  reg [7:0] val_q;
  reg [7:0] en_q;
  // ****
  // Pin drive
  // ****
  // Released pins show the inverse level, so a stale value never passes.
  assign host_pin = (val_q & en_q) | (~val_q & ~en_q);
  initial begin
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    cmd_sub_sel = 1'b0;
    val_q = 8'h00;
    en_q = 8'h00;
  end
  task par_write(input cs_n, input sub, input [7:0] d);
    @(posedge pclk);
    host_cs_n <= cs_n;
    cmd_sub_sel <= sub;
    val_q <= d;
    en_q <= 8'hff;
    host_wr_n <= 1'b0;
    repeat (5) @(posedge pclk);
    host_wr_n <= 1'b1;
    repeat (3) @(posedge pclk);
    host_cs_n <= 1'b1;
    en_q <= 8'h00;
    repeat (5) @(posedge pclk);
  endtask
  task par_read(output [7:0] d);
    @(posedge pclk);
    host_rd_n <= 1'b0;
    repeat (6) @(posedge pclk);
    d = host_data_out;
    host_rd_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // Link clock of 48 ns, low and still between frames.
  task ser_byte(input sub, input [7:0] d, output [7:0] st);
    integer   i;
    reg [7:0] sh;
    sh = d;
    @(posedge pclk);
    en_q <= 8'hd0;
    val_q <= {sh[7], 7'h00};
    cmd_sub_sel <= sub;
    host_cs_n <= 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      repeat (6) @(posedge pclk);
      st[i] = host_data_out[5];
      val_q[6] <= 1'b1;
      sh = sh << 1;
      repeat (6) @(posedge pclk);
      val_q <= {sh[7], 7'h00};
    end
    repeat (6) @(posedge pclk);
    host_cs_n <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
endmodule // host_model

//--- tb/voice_host_pins_tb_top.sv
// Self-checking bench for the voice host pin block.
// Assumes the host model and the bound checker of this folder.
`timescale 1ns/100ps
`include "voice_host_map.vh"
module voice_host_pins_tb_top;
  reg         pclk, presetn, psel, penable, pwrite, serial_sel, status_sel;
  reg         voice_mem_bus_grant_n;
  reg  [7:0]  paddr, voice_mem_rdata, b;
  reg  [31:0] pwdata, r;
  reg         e;
  wire        pready, pslverr, irq, host_cs_n, host_wr_n, host_rd_n, cmd_sub_sel;
  wire        voice_mem_addr_oe, voice_mem_oe_n, voice_mem_oe_n_oe, osc_run;
  wire [7:0]  host_data_out, host_data_oe, host_pin, host_data_in;
  wire [31:0] prdata;
  wire [23:0] voice_mem_addr;
  wire [13:0] left_audio_out, right_audio_out;
  wire [3:0]  factory_test_in = 4'h0;
  integer     bad_count, comparisons, cycles, k;
  assign host_data_in = (host_data_oe & host_data_out) | (~host_data_oe & host_pin);
  voice_host_pins i_dut (.*);
  host_model i_host (.*);
  always #2 pclk = ~pclk;
  // ****
  // Tasks
  // ****
  task check(input string what, input [31:0] exp, input [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input string what, input [7:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, r);
  endtask
  task test_done;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    {pclk, presetn, psel, penable, pwrite, serial_sel} = 6'h00;
    {paddr, pwdata, voice_mem_rdata} = 48'h0;
    status_sel = 1'b1;
    voice_mem_bus_grant_n = 1'b1;
    {bad_count, comparisons, cycles} = 96'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", `VH_CTRL_OFS, 32'h0);
    rd("irq_stat", `VH_IRQ_STAT_OFS, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    check("unmapped err", 1, e);
    apb(1'b1, `VH_CTRL_OFS, 32'h1);
    apb(1'b1, `VH_AUDIO_OFS, 32'h2abc_1234);
    repeat (2) @(posedge pclk);
    check("audio", 32'h2abc_1234, {2'h0, right_audio_out, 2'h0, left_audio_out});
    check("osc_run", 1, osc_run);
    presetn <= 1'b0;
    @(posedge pclk);
    check("reset quiet", 0, {osc_run, left_audio_out, right_audio_out});
    presetn <= 1'b1;
    $display("Test reset done");
    apb(1'b1, `VH_MEM_OFS, 32'h0112_3456);
    rd("mem reg", `VH_MEM_OFS, 32'h0112_3456);
    voice_mem_bus_grant_n <= 1'b0;
    voice_mem_rdata <= 8'h5a;
    repeat (4) @(posedge pclk);
    check("mem addr", 24'h123456, voice_mem_addr);
    check("mem oe", 0, voice_mem_oe_n);
    check("mem drive", 3, {voice_mem_addr_oe, voice_mem_oe_n_oe});
    voice_mem_bus_grant_n <= 1'b1;
    repeat (4) @(posedge pclk);
    check("mem float", 0, {voice_mem_addr_oe, voice_mem_oe_n_oe});
    $display("Test memory done");
    apb(1'b1, `VH_IRQ_EN_OFS, 32'hf);
    for (k = 0; k < 2; k = k + 1) begin
      i_host.par_write(1'b0, k[0], 8'ha5 ^ k[7:0]);
      check("irq", 1, irq);
      rd("irq_stat", `VH_IRQ_STAT_OFS, 32'h1 << k);
      rd("rx", `VH_RX_OFS, {22'h0, 1'b1, k[0], 8'ha5 ^ k[7:0]});
      apb(1'b1, `VH_IRQ_CLR_OFS, 32'hf);
      rd("stat clr", `VH_IRQ_STAT_OFS, 32'h0);
      check("irq clr", 0, irq);
    end
    apb(1'b1, `VH_IRQ_EN_OFS, 32'h0);
    i_host.par_write(1'b0, 1'b0, 8'h11);
    i_host.par_write(1'b0, 1'b0, 8'h22);
    check("irq masked", 0, irq);
    rd("overrun", `VH_IRQ_STAT_OFS, 32'h5);
    rd("rx new", `VH_RX_OFS, 32'h222);
    apb(1'b1, `VH_IRQ_CLR_OFS, 32'hf);
    i_host.par_write(1'b1, 1'b0, 8'h33);
    rd("cs high", `VH_IRQ_STAT_OFS, 32'h0);
    serial_sel <= 1'b1;
    i_host.par_write(1'b0, 1'b0, 8'h44);
    rd("strap serial", `VH_IRQ_STAT_OFS, 32'h0);
    serial_sel <= 1'b0;
    $display("Test host write done");
    apb(1'b1, `VH_CHAN_OFS, 32'h36);
    for (k = 0; k < 2; k = k + 1) begin
      status_sel <= k[0];
      i_host.par_read(b);
      check("par status", k ? 8'h06 : 8'h0c, b);
    end
    check("par float", 0, host_data_oe);
    rd("read event", `VH_IRQ_STAT_OFS, 32'h8);
    $display("Test host read done");
    serial_sel <= 1'b1;
    repeat (5) @(posedge pclk);
    check("serial oe", 8'h2f, host_data_oe);
    check("serial chan", 4'h6, host_data_out[3:0]);
    for (k = 0; k < 2; k = k + 1) begin
      i_host.ser_byte(k[0], 8'hc5 ^ k[7:0], b);
      check("serial status", 8'h06, b);
      rd("serial rx", `VH_RX_OFS, {22'h0, 1'b1, k[0], 8'hc5 ^ k[7:0]});
    end
    rd("pin", `VH_PIN_OFS, 32'h35a);
    $display("Test serial done");
    test_done;
  end
endmodule // voice_host_pins_tb_top
